// ==== design/cawd_pkg.sv ====
package cawd_pkg;

	// ----------------------------------------
	// Register addresses
	// ----------------------------------------
	localparam logic [7:0] ADDR_CONTROL     = 8'hD8;
	localparam logic [7:0] ADDR_MODE        = 8'hD9;
	localparam logic [7:0] ADDR_CNT_LOW     = 8'hE9;
	localparam logic [7:0] ADDR_CNT_HIGH    = 8'hF9;
	localparam logic [7:0] ADDR_OFFSET_BYTE = 8'hFE;
	localparam logic [7:0] ADDR_UPDATE_BYTE = 8'hD2;
	localparam logic [7:0] ADDR_M5_MODE     = 8'hCE;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CTL_OVF   = 7;
	localparam int CTL_RUN   = 6;
	localparam int CTL_M5    = 5;
	localparam int MD_IDLE   = 7;
	localparam int MD_WDEN   = 6;
	localparam int MD_LOCK   = 5;
	localparam int MD_CPS_LO = 1;
	localparam int MD_OVF_IE = 0;

	// ----------------------------------------
	// Reset values and constants
	// ----------------------------------------
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] MODE_RESET    = 8'h40;
	localparam logic [7:0] MODE_WMASK    = 8'hEF;
	localparam logic [7:0] M5_SWTIMER    = 8'h48;
	localparam logic [2:0] CPS_DIV12     = 3'h0;
	localparam logic [2:0] CPS_DIV4      = 3'h1;
	localparam logic [2:0] CPS_SYSCLK    = 3'h4;
	localparam logic [3:0] DIV12_LAST    = 4'hB;
	localparam logic [3:0] DIV4_LAST     = 4'h3;
	localparam int         WD_PULSE_CYC  = 1;

	// ----------------------------------------
	// State of the block
	// ----------------------------------------
	typedef struct packed {
		logic [7:0]  control;
		logic [7:0]  mode;
		logic [15:0] count;
		logic [7:0]  offset_byte;
		logic [7:0]  update_byte;
		logic [7:0]  m5_mode;
		logic [3:0]  prescale;
		logic        ext_d1;
		logic        ext_d2;
		logic        ext_prev;
		logic        wd_reset;
		logic [7:0]  rdata;
		logic        irq;
	} cawd_state_s;

endpackage

// ==== design/cawd_top.sv ====
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Module 5 is the watchdog when enabled
// - Watchdog enable set after every reset
// - Reset defaults: divide by 12, zero bytes
// - Counter forced running except while idle bit set and CPU idle, run writes still stored
// - Counter byte writes ignored while enabled
// - Clock select and idle bit frozen
// - Module 5 forced to timer, mode locked
// - Run bit reads zero unless software set
// - Update write loads high byte plus offset
// - Low overflow at update match resets system
// - Timeout is 256 times offset plus remainder
// - Writing one to module 5 flag resets
// - Enable or lock enables; lock holds till reset
// - Counter wrap sets overflow flag, software clears
// - Run bit starts and stops the counter only while watchdog disabled
// - Module events set flags, never hardware cleared
module cawd_top
	import cawd_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       reset,
	input  wire logic       sfr_wr,
	input  wire logic       sfr_rd,
	input  wire logic [7:0] sfr_addr,
	input  wire logic [7:0] sfr_wdata,
	input  wire logic       cpu_idle,
	input  wire logic       timer0_ovf,
	input  wire logic       ext_clk_pin,
	input  wire logic [4:0] module_events,
	output var  logic [7:0] sfr_rdata,
	output var  logic       wd_system_reset,
	output var  logic       counter_array_irq
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	cawd_state_s cur;
	cawd_state_s nxt;

	logic       wd_on;
	logic       tick;
	logic       running;
	logic       low_ovf;
	logic [2:0] cps;
	logic [7:0] next_update;
	logic [7:0] flags_set;

	function automatic logic wr_hit(input logic we, input logic [7:0] a, input logic [7:0] target);
		wr_hit = we && (a == target);
	endfunction

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		nxt = cur;
		wd_on = cur.mode[MD_WDEN] | cur.mode[MD_LOCK];
		cps = cur.mode[MD_CPS_LO +: 3];
		nxt.ext_d1 = ext_clk_pin;
		nxt.ext_d2 = cur.ext_d1;
		nxt.ext_prev = cur.ext_d2;
		nxt.prescale = cur.prescale + 4'h1;
		tick = 1'b0;
		unique case (cps)
			CPS_DIV12: begin
				tick = (cur.prescale == DIV12_LAST);
				if (tick) begin
					nxt.prescale = 4'h0;
				end
			end
			CPS_DIV4: begin
				tick = (cur.prescale >= DIV4_LAST);
				if (tick) begin
					nxt.prescale = 4'h0;
				end
			end
			3'h2: tick = timer0_ovf;
			3'h3: tick = cur.ext_prev & ~cur.ext_d2;
			CPS_SYSCLK: tick = 1'b1;
			3'h5: tick = cur.ext_d2 & ~cur.ext_prev;
			default: tick = 1'b0;
		endcase
		running = (cur.control[CTL_RUN] | wd_on) && !(cur.mode[MD_IDLE] && cpu_idle);
		low_ovf = running && tick && (cur.count[7:0] == 8'hFF);
		if (running && tick) begin
			nxt.count = cur.count + 16'h0001;
			if (cur.count == 16'hFFFF) begin
				nxt.control[CTL_OVF] = 1'b1;
			end
		end
		flags_set = {3'h0, module_events};
		next_update = cur.count[15:8] + cur.offset_byte;
		if (sfr_wr) begin
			if (wr_hit(sfr_wr, sfr_addr, ADDR_CONTROL)) begin
				nxt.control[CTL_OVF] = sfr_wdata[CTL_OVF];
				nxt.control[CTL_RUN] = sfr_wdata[CTL_RUN];
				nxt.control[5:0] = sfr_wdata[5:0];
				if (running && tick && cur.count == 16'hFFFF) begin
					nxt.control[CTL_OVF] = 1'b1;
				end
			end
			if (wr_hit(sfr_wr, sfr_addr, ADDR_MODE)) begin
				if (wd_on) begin
					nxt.mode[MD_WDEN] = sfr_wdata[MD_WDEN];
					nxt.mode[MD_LOCK] = cur.mode[MD_LOCK] | sfr_wdata[MD_LOCK];
					nxt.mode[MD_OVF_IE] = sfr_wdata[MD_OVF_IE];
				end else begin
					nxt.mode = sfr_wdata & MODE_WMASK;
				end
			end
			if (!wd_on && wr_hit(sfr_wr, sfr_addr, ADDR_CNT_LOW)) begin
				nxt.count[7:0] = sfr_wdata;
			end
			if (!wd_on && wr_hit(sfr_wr, sfr_addr, ADDR_CNT_HIGH)) begin
				nxt.count[15:8] = sfr_wdata;
			end
			if (wr_hit(sfr_wr, sfr_addr, ADDR_OFFSET_BYTE)) begin
				nxt.offset_byte = sfr_wdata;
			end
			if (wr_hit(sfr_wr, sfr_addr, ADDR_UPDATE_BYTE)) begin
				nxt.update_byte = wd_on ? next_update : sfr_wdata;
			end
			if (!wd_on && wr_hit(sfr_wr, sfr_addr, ADDR_M5_MODE)) begin
				nxt.m5_mode = sfr_wdata;
			end
		end
		nxt.control[5:0] = nxt.control[5:0] | flags_set[5:0];
		if (wd_on) begin
			nxt.m5_mode = M5_SWTIMER;
		end
		nxt.wd_reset = wd_on && ((low_ovf && cur.update_byte == cur.count[15:8])
			|| (wr_hit(sfr_wr, sfr_addr, ADDR_CONTROL) && sfr_wdata[CTL_M5]));
		nxt.irq = (nxt.control[CTL_OVF] & nxt.mode[MD_OVF_IE]) | (|nxt.control[5:0] & nxt.m5_mode[0]);
		nxt.rdata = 8'h00;
		if (sfr_rd) begin
			unique case (sfr_addr)
				ADDR_CONTROL:     nxt.rdata = cur.control;
				ADDR_MODE:        nxt.rdata = cur.mode & MODE_WMASK;
				ADDR_CNT_LOW:     nxt.rdata = cur.count[7:0];
				ADDR_CNT_HIGH:    nxt.rdata = cur.count[15:8];
				ADDR_OFFSET_BYTE: nxt.rdata = cur.offset_byte;
				ADDR_UPDATE_BYTE: nxt.rdata = cur.update_byte;
				ADDR_M5_MODE:     nxt.rdata = cur.m5_mode;
				default:          nxt.rdata = 8'h00;
			endcase
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (reset || cur.wd_reset) begin
			cur <= '0;
			cur.control <= CONTROL_RESET;
			cur.mode <= MODE_RESET;
			cur.wd_reset <= 1'b0;
		end else begin
			cur <= nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (reset) begin
			wd_system_reset <= 1'b0;
			sfr_rdata <= 8'h00;
			counter_array_irq <= 1'b0;
		end else begin
			wd_system_reset <= nxt.wd_reset && !cur.wd_reset;
			sfr_rdata <= nxt.rdata;
			counter_array_irq <= nxt.irq;
		end
	end

endmodule

`default_nettype wire

// ==== verification/cawd_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module cawd_monitor
	import cawd_pkg::*;
(
	input wire logic       mclk,
	input wire logic       reset,
	input wire logic       sfr_wr,
	input wire logic       sfr_rd,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata,
	input wire logic       wd_system_reset,
	input wire logic       counter_array_irq
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	a_pulse_one_cycle: assert property (wd_system_reset |=> !wd_system_reset)
		else $error("reset pulse too long");
	a_outputs_clean: assert property ($fell(reset) |-> !wd_system_reset && !counter_array_irq && sfr_rdata == 8'h00)
		else $error("outputs not clear after reset");
	a_mode_after_reset: assert property ($fell(reset) ##0 (sfr_rd && sfr_addr == ADDR_MODE) |-> ##1 sfr_rdata == MODE_RESET)
		else $error("mode not at default");
	a_run_reads_zero: assert property ($fell(reset) ##0 (sfr_rd && sfr_addr == ADDR_CONTROL) |-> ##1 sfr_rdata == 8'h00 ##1 sfr_rdata == 8'h00)
		else $error("control not zero");
	a_flag_forces_reset: assert property ($fell(reset) ##0 (sfr_wr && sfr_addr == ADDR_CONTROL && sfr_wdata[CTL_M5]) |-> ##[1:3] wd_system_reset)
		else $error("no forced reset");
	a_lock_holds_on: assert property ((sfr_wr && sfr_addr == ADDR_MODE && sfr_wdata[MD_LOCK]) ##2 (sfr_wr && sfr_addr == ADDR_MODE)
		##2 (sfr_wr && sfr_addr == ADDR_CONTROL && sfr_wdata[CTL_M5]) |-> ##[1:3] wd_system_reset)
		else $error("lock did not hold");
	a_defaults_restored: assert property (wd_system_reset ##[1:3] (sfr_rd && sfr_addr == ADDR_MODE) |-> ##1 sfr_rdata == MODE_RESET)
		else $error("mode not restored");
	a_rdata_quiet: assert property ((!sfr_rd) [*4] |=> sfr_rdata == 8'h00)
		else $error("read data without read");
endmodule
bind cawd_top cawd_monitor u_mon (.mclk(mclk), .reset(reset), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr),
	.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .wd_system_reset(wd_system_reset), .counter_array_irq(counter_array_irq));
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import cawd_pkg::*;
	logic       mclk, reset, sfr_wr, sfr_rd, irq, wdr;
	logic [7:0] sfr_addr, sfr_wdata, rdata;
	logic [4:0] ev;
	integer     failures, n_checks, seed, n, off, pulses, base;
	time        t0;
	cawd_top DUT (.mclk(mclk), .reset(reset), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr),
		.sfr_wdata(sfr_wdata), .cpu_idle(1'b0), .timer0_ovf(1'b0), .ext_clk_pin(1'b0), .module_events(ev),
		.sfr_rdata(rdata), .wd_system_reset(wdr), .counter_array_irq(irq));
	initial begin
		mclk = 0;
		forever #4 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		if (wdr === 1'b1) pulses++;
	end
	task chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task give_verdict;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task rst;
		reset <= 1'b1;
		repeat (20) @(posedge mclk);
		reset <= 1'b0;
		t0 = $time;
		base = pulses;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		sfr_wr <= 1'b1;
		sfr_addr <= a;
		sfr_wdata <= d;
		@(posedge mclk);
		sfr_wr <= 1'b0;
		@(posedge mclk);
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e, input string what);
		logic [7:0] v;
		sfr_rd <= 1'b1;
		sfr_addr <= a;
		@(posedge mclk);
		sfr_rd <= 1'b0;
		#1 v = rdata;
		@(posedge mclk);
		chk(v, e, what);
	endtask
	task wait_rst(input integer lim);
		n = 0;
		while (pulses == base && n < lim) begin
			@(posedge mclk);
			#1 n++;
		end
		@(posedge mclk);
	endtask
	initial begin
		repeat (40000) @(posedge mclk);
		failures++;
		give_verdict;
	end
	initial begin
		{reset, sfr_wr, sfr_rd, sfr_addr, sfr_wdata, ev} = {1'b1, 2'b00, 16'h0000, 5'h00};
		failures = 0;
		n_checks = 0;
		seed = 44666;
		pulses = 0;
		base = 0;
		rst;
		rd(ADDR_MODE, MODE_RESET, "mode");
		rd(ADDR_CONTROL, 8'h00, "control");
		wr(ADDR_CNT_HIGH, 8'h55);
		rd(ADDR_CNT_HIGH, 8'h00, "count high");
		wr(ADDR_MODE, 8'hCE);
		rd(ADDR_MODE, MODE_RESET, "frozen mode");
		rd(ADDR_OFFSET_BYTE, 8'h00, "offset");
		wait_rst(4000);
		chk(8'(($time - t0) / 8 >= 3068 && ($time - t0) / 8 <= 3084), 8'h01, "default timeout");
		rd(ADDR_MODE, MODE_RESET, "mode after timeout");
		rst;
		wr(ADDR_CONTROL, 8'h20);
		wait_rst(6);
		chk(8'(n < 6), 8'h01, "forced reset");
		rst;
		wr(ADDR_MODE, 8'h60);
		wr(ADDR_MODE, 8'h00);
		wr(ADDR_CONTROL, 8'h20);
		wait_rst(6);
		chk(8'(n < 6), 8'h01, "locked reset");
		rst;
		wr(ADDR_MODE, 8'h00);
		wr(ADDR_CONTROL, 8'h20);
		ev <= 5'($random(seed));
		wait_rst(6);
		chk(8'(n), 8'h06, "disabled no reset");
		rd(ADDR_CONTROL, {3'b001, ev}, "flags");
		wr(ADDR_M5_MODE, 8'h01);
		#1 chk(8'(irq), 8'h01, "flag irq");
		off = $random(seed) & 3;
		wr(ADDR_OFFSET_BYTE, 8'(off));
		wr(ADDR_MODE, MODE_RESET);
		wr(ADDR_UPDATE_BYTE, 8'hAA);
		wait_rst(13000);
		chk(8'(n >= 3072 * (off + 1) - 24 && n <= 3072 * (off + 1) + 12), 8'h01, "offset timeout");
		give_verdict;
	end
endmodule
`default_nettype wire
